// [src/isp_top.sv]
`timescale 1ns/1ps
// interrupt source prioritiser: presents winning level and event code to the core
module isp_top
  import isp_pkg::*;
#(
  parameter int NSRC = ISP_NSRC,
  parameter bit LATER_VARIANT = 1'b1
)(
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // chip state
  input wire logic standby_mode,
  input wire logic sleep_mode,
  input wire logic rtc_tick,
  // external pins
  input wire logic nmi_pin,
  input wire logic [3:0] encoded_request_pins,
  // intc_control_reg bits
  input wire logic edge_polarity_select,
  input wire logic nmi_pass_block,
  input wire logic independent_pin_mode,
  // priority levels (priority_regs_a_to_d and extra_priority_setting_reg)
  input wire logic prio_we,
  input wire logic [15:0] priority_reg_d_wdata,
  input wire logic [NSRC*4-1:0] peri_level_wdata,
  output logic [15:0] priority_reg_d,
  output logic [NSRC*4-1:0] peri_level,
  // peripheral requests, index 0 highest default order
  input wire logic [NSRC-1:0] peri_req,
  // cpu core
  input wire logic cpu_block_bit,
  input wire logic [3:0] cpu_mask_level,
  input wire logic cpu_accept,
  output logic int_req,
  output logic [4:0] int_level,
  output logic [11:0] event_code_reg,
  output logic [NSRC-1:0] pending_source_reg,
  output logic nmi_pending
);
  // filter sampling: bus clock normally, rtc tick in standby
  logic filt_en;
  logic [3:0] irl_stable_n;
  assign filt_en = standby_mode ? rtc_tick : 1'b1;

  isp_irl_filter #(.SAMPLES(ISP_FILT_SAMPLES)) u_filter (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .sample_en(filt_en),
    .pins_n(encoded_request_pins),
    .stable_n(irl_stable_n)
  );

  // nmi edge detect with blind window after select change
  isp_edge_e edge_st, next_edge_st;
  logic [2:0] blind_cnt, next_blind_cnt;
  logic nmi_prev, sel_prev, next_nmi_pending;
  logic nmi_edge;

  assign nmi_edge = edge_polarity_select ? (nmi_pin && !nmi_prev)
                                         : (!nmi_pin && nmi_prev);

  logic nmi_taken;
  logic nmi_allowed;
  assign nmi_allowed = !cpu_block_bit || sleep_mode || standby_mode
                       || nmi_pass_block;

  always_comb
  begin
    next_edge_st = edge_st;
    next_blind_cnt = blind_cnt;
    next_nmi_pending = nmi_pending;
    case (edge_st)
      ISP_IDLE:
      begin
        if (edge_polarity_select != sel_prev)
        begin
          next_edge_st = ISP_BLIND;
          next_blind_cnt = 3'(ISP_EDGE_BLIND_CYC - 1);
        end
        else if (nmi_edge)
          next_nmi_pending = 1'b1;
      end
      ISP_BLIND:
      begin
        if (blind_cnt == 3'd0)
          next_edge_st = ISP_IDLE;
        else
          next_blind_cnt = blind_cnt - 3'd1;
      end
      default:
        next_edge_st = ISP_IDLE;
    endcase
    // a fresh edge in the accept cycle is kept: set wins
    if (nmi_taken && !(edge_st == ISP_IDLE && nmi_edge
        && edge_polarity_select == sel_prev))
      next_nmi_pending = 1'b0;
  end

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      edge_st <= ISP_IDLE;
      blind_cnt <= 3'd0;
      nmi_prev <= 1'b0;
      // constant reset: a high select costs one blind window after reset
      sel_prev <= 1'b0;
      nmi_pending <= 1'b0;
    end
    else
    begin
      edge_st <= next_edge_st;
      blind_cnt <= next_blind_cnt;
      nmi_prev <= nmi_pin;
      sel_prev <= edge_polarity_select;
      nmi_pending <= next_nmi_pending;
    end
  end

  // priority levels
  logic [15:0] next_prio_d;
  logic [NSRC*4-1:0] next_peri_level;
  always_comb
  begin
    next_prio_d = prio_we ? priority_reg_d_wdata : priority_reg_d;
    next_peri_level = prio_we ? peri_level_wdata : peri_level;
  end

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      priority_reg_d <= ISP_PRIO_D_RST;
      peri_level <= '0;
    end
    else
    begin
      priority_reg_d <= next_prio_d;
      peri_level <= next_peri_level;
    end
  end

  // encoded level: 0000 means 15, 1111 means none
  function automatic logic [3:0] irl_level(input logic [3:0] pins_n);
    irl_level = ~pins_n;
  endfunction

  function automatic logic [11:0] step_code(input logic [11:0] base,
                                            input logic [11:0] step,
                                            input logic [3:0] idx);
    step_code = base + step * {8'h00, idx};
  endfunction

  // arbitration, greater-or-equal on a descending loop keeps the lower index on ties
  logic [4:0] best_lvl;
  logic [11:0] best_code;
  logic best_is_nmi;
  logic [NSRC-1:0] best_peri;
  always_comb
  begin
    logic [3:0] lvl;
    logic [3:0] plvl;
    lvl = 4'h0;
    plvl = 4'h0;
    best_lvl = 5'h00;
    best_code = ISP_EVT_NONE;
    best_is_nmi = 1'b0;
    best_peri = '0;
    if (nmi_pending && nmi_allowed)
    begin
      best_lvl = ISP_LVL_NMI;
      best_code = ISP_EVT_NMI;
      best_is_nmi = 1'b1;
    end
    else
    begin
      if (!independent_pin_mode)
      begin
        lvl = irl_level(irl_stable_n);
        if (lvl != 4'h0)
        begin
          best_lvl = {1'b0, lvl};
          best_code = step_code(ISP_EVT_IRL_BASE, ISP_EVT_IRL_STEP, ~lvl);
        end
      end
      else
      begin
        for (int i = 3; i >= 0; i--)
        begin
          if (LATER_VARIANT)
            plvl = priority_reg_d[(3 - i) * 4 +: 4];
          else
            plvl = (i == 0) ? ISP_FIX_LVL0 : (i == 1) ? ISP_FIX_LVL1 :
                   (i == 2) ? ISP_FIX_LVL2 : ISP_FIX_LVL3;
          if (!irl_stable_n[i] && plvl != 4'h0 && {1'b0, plvl} >= best_lvl)
          begin
            best_lvl = {1'b0, plvl};
            best_code = step_code(ISP_EVT_IRL_BASE, ISP_EVT_IRL_STEP,
                                  4'(3 * i + 2));
          end
        end
      end
      for (int j = NSRC - 1; j >= 0; j--)
      begin
        plvl = peri_level[j * 4 +: 4];
        // level 0 masks the source; ties go to lower index
        if (peri_req[j] && plvl != 4'h0 && {1'b0, plvl} >= best_lvl
            && !(best_lvl != 5'h00 && {1'b0, plvl} == best_lvl && best_peri == '0))
        begin
          best_lvl = {1'b0, plvl};
          best_code = step_code(ISP_EVT_PERI_BASE, ISP_EVT_PERI_STEP, 4'(j));
          best_peri = '0;
          best_peri[j] = 1'b1;
        end
      end
    end
  end

  // maskable requests need a clear block bit and a level above the mask
  logic offer;
  assign offer = best_is_nmi
                 || (!cpu_block_bit && best_lvl > {1'b0, cpu_mask_level});
  assign nmi_taken = cpu_accept && offer && best_is_nmi;
  assign int_req = offer;

  logic [4:0] next_int_level;
  logic [11:0] next_event_code;
  always_comb
  begin
    next_int_level = best_lvl;
    next_event_code = event_code_reg;
    if (cpu_accept && offer)
      next_event_code = best_code;
  end

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      int_level <= 5'h00;
      event_code_reg <= ISP_EVT_NONE;
      pending_source_reg <= '0;
    end
    else
    begin
      int_level <= next_int_level;
      event_code_reg <= next_event_code;
      pending_source_reg <= peri_req;
    end
  end
  // the mask level is only an input here: never driven

  nmi_level_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    (nmi_pending && nmi_allowed) |=> int_level == ISP_LVL_NMI)
    else $error("nmi not presented at level 16");
  nmi_blocked_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    (cpu_block_bit && !sleep_mode && !standby_mode && !nmi_pass_block)
      |-> !best_is_nmi)
    else $error("nmi passed a set block bit");
  nmi_sleep_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    (nmi_pending && (sleep_mode || standby_mode)) |-> int_req)
    else $error("nmi held off in sleep or standby");
  nmi_option_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    (nmi_pending && nmi_pass_block) |-> best_is_nmi)
    else $error("pass option did not admit nmi");
  edge_rise_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    (edge_st == ISP_IDLE && edge_polarity_select && $stable(edge_polarity_select)
      && $rose(nmi_pin) && !nmi_taken) |=> nmi_pending)
    else $error("rising edge missed");
  edge_blind_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    $changed(edge_polarity_select) |=> edge_st == ISP_BLIND [*5])
    else $error("blind window shorter than expected");
  masked_lvl_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    (!nmi_pending && irl_stable_n == ISP_IRL_NONE && peri_level == '0)
      |-> !int_req)
    else $error("request from masked source");
  encoded_lvl_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    (!nmi_pending && !independent_pin_mode && peri_req == '0)
      |=> int_level == {1'b0, ~$past(irl_stable_n)})
    else $error("encoded level wrong");
  mask_cmp_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    (int_req && !best_is_nmi) |-> best_lvl > {1'b0, cpu_mask_level})
    else $error("request offered at or below mask");
  nmi_hold_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    (nmi_pending && !nmi_taken) |=> nmi_pending)
    else $error("nmi dropped before it was taken");
  nmi_clear_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    (nmi_taken && !nmi_edge) |=> !nmi_pending)
    else $error("nmi still pending after it was taken");
  edge_fall_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    (edge_st == ISP_IDLE && !edge_polarity_select && $stable(edge_polarity_select)
      && $fell(nmi_pin) && $past(resetn)) |=> nmi_pending)
    else $error("falling edge missed");
  nmi_code_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    (cpu_accept && int_req && best_is_nmi) |=> event_code_reg == ISP_EVT_NMI)
    else $error("nmi accepted with a wrong event code");
  pin_idle_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    (!nmi_pending && independent_pin_mode && irl_stable_n == ISP_IRL_NONE
      && peri_req == '0) |=> int_level == 5'h00)
    else $error("independent pins offered a request while all high");
endmodule

// [src/isp_pkg.sv]
// How it works
// - requests ranked 16 (most urgent) down to 1; 0 is no request
// - a source with level 0 is masked and its request ignored
// - nonmaskable request is level 16, taken when block bit clear, else held
// - in sleep or standby the nonmaskable request is taken despite the block bit
// - option bit lets the nonmaskable request pass a set block bit
// - nonmaskable pin is edge detected; select bit picks rising or falling
// - after the edge select changes, detection pauses for 7 clocks: the change cycle and 6 blind cycles
// - accepting any request never alters the cpu mask level
// - encoded pins active low: 0000 is level 15, 1111 is no request
// - encoded pins sampled each clock; three equal samples make a new level
// - in standby the filter runs on the 32.768 kHz tick; no tick, no wake
// - independent-pin mode makes the four pins separate active-low requests
// - basic variant fixed levels 13,10,7,4; lower pin number wins
// - later variants take each pin level from a 4-bit field of register D
// - nine peripheral modules may raise internal requests
// - each accepted source loads its own event code
// - each peripheral has a 15..0 level from registers A..D and extra reg
// - flag change with block bit clear may start handling with code 0; here event_code_reg keeps its last code unless an offered request is accepted
// - peripheral levels reset to 0
// - equal levels at once are resolved by a fixed default order
package isp_pkg;
  localparam int ISP_NSRC = 9;
  localparam logic [4:0] ISP_LVL_NMI = 5'h10;
  localparam logic [3:0] ISP_IRL_NONE = 4'hF;
  localparam int ISP_FILT_SAMPLES = 3;
  localparam int ISP_EDGE_BLIND_CYC = 6;
  localparam logic [15:0] ISP_PRIO_D_RST = 16'hDA74;
  localparam logic [15:0] ISP_PRIO_RST = 16'h0000;
  localparam logic [31:0] ISP_EXTRA_RST = 32'h0000_0000;
  localparam logic [3:0] ISP_FIX_LVL0 = 4'hD;
  localparam logic [3:0] ISP_FIX_LVL1 = 4'hA;
  localparam logic [3:0] ISP_FIX_LVL2 = 4'h7;
  localparam logic [3:0] ISP_FIX_LVL3 = 4'h4;
  localparam logic [11:0] ISP_EVT_NONE = 12'h000;
  localparam logic [11:0] ISP_EVT_NMI = 12'h1C0;
  localparam logic [11:0] ISP_EVT_IRL_BASE = 12'h200;
  localparam logic [11:0] ISP_EVT_IRL_STEP = 12'h020;
  localparam logic [11:0] ISP_EVT_PERI_BASE = 12'h600;
  localparam logic [11:0] ISP_EVT_PERI_STEP = 12'h020;
  typedef enum logic [1:0] {ISP_IDLE = 2'b00, ISP_BLIND = 2'b01} isp_edge_e;
endpackage

// [src/isp_irl_filter.sv]
`timescale 1ns/1ps
// three-sample agreement filter on the encoded pins
module isp_irl_filter
  import isp_pkg::*;
#(
  parameter int SAMPLES = ISP_FILT_SAMPLES
)(
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // sampling
  input wire logic sample_en,
  input wire logic [3:0] pins_n,
  // filtered level
  output logic [3:0] stable_n
);
  logic [3:0] last;
  logic [1:0] agree;
  logic [3:0] next_last;
  logic [1:0] next_agree;
  logic [3:0] next_stable_n;

  always_comb
  begin
    next_last = last;
    next_agree = agree;
    next_stable_n = stable_n;
    if (sample_en)
    begin
      next_last = pins_n;
      if (pins_n != last)
        next_agree = 2'd1;
      else if (agree < 2'(SAMPLES))
        next_agree = agree + 2'd1;
      // a new level counts only after SAMPLES equal samples
      if (pins_n == last && agree == 2'(SAMPLES - 1))
        next_stable_n = pins_n;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      last <= ISP_IRL_NONE;
      agree <= 2'd0;
      stable_n <= ISP_IRL_NONE;
    end
    else
    begin
      last <= next_last;
      agree <= next_agree;
      stable_n <= next_stable_n;
    end
  end

  filter_hold_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    (stable_n != $past(stable_n)) |->
      $past(pins_n) == stable_n && $past(pins_n, 2) == stable_n)
    else $error("filtered level changed without agreeing samples");
endmodule

// [sim/isp_core_model.sv]
`timescale 1ns/1ps
// stand-in for the cpu core: takes the offered request after a chosen lag
module isp_core_model
  import isp_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // offer from the prioritiser
  input wire logic acc_en,
  input wire logic [3:0] lag,
  input wire logic int_req,
  input wire logic [4:0] int_level,
  input wire logic [3:0] cpu_mask_level,
  // acceptance pulse
  output logic cpu_accept
);
  logic [3:0] wait_cnt;
  logic done;

  always @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      cpu_accept <= 1'b0;
      wait_cnt <= 4'h0;
      done <= 1'b0;
    end
    else
    begin
      cpu_accept <= 1'b0;
      if (!acc_en)
      begin
        done <= 1'b0;
        wait_cnt <= 4'h0;
      end
      // level 16 always clears a 4-bit mask, so nmi is never held here
      else if (!done && int_req && int_level > {1'b0, cpu_mask_level})
      begin
        if (wait_cnt == lag)
        begin
          cpu_accept <= 1'b1;
          done <= 1'b1;
        end
        wait_cnt <= wait_cnt + 4'h1;
      end
    end
  end
endmodule

// [sim/interrupt_source_prioritizer_test.sv]
`timescale 1ns/1ps
module interrupt_source_prioritizer_test;
  import isp_pkg::*;
  logic sys_clk = 0;
  logic resetn = 0;
  logic standby_mode = 0;
  logic sleep_mode = 0;
  logic rtc_tick = 0;
  logic nmi_pin = 0;
  logic [3:0] encoded_request_pins = 4'hF;
  logic [3:0] cpu_mask_level = 4'h0;
  logic [3:0] lag = 4'h0;
  logic edge_polarity_select = 1;
  logic nmi_pass_block = 0;
  logic independent_pin_mode = 0;
  logic prio_we = 0;
  logic cpu_block_bit = 0;
  logic acc_en = 0;
  logic cpu_accept, int_req, nmi_pending;
  logic [15:0] priority_reg_d_wdata = 16'hDA74;
  logic [15:0] priority_reg_d;
  logic [35:0] peri_level_wdata = '0;
  logic [35:0] peri_level;
  logic [8:0] peri_req = '0;
  logic [8:0] pending_source_reg;
  logic [8:0] win;
  logic [4:0] int_level;
  logic [11:0] event_code_reg;
  int error_cnt = 0;
  int checks_done = 0;
  int cyc_cnt = 0;
  integer seed = 32'h69ee96c3;

  isp_top isp_top_i (.sys_clk(sys_clk), .resetn(resetn), .standby_mode(standby_mode),
    .sleep_mode(sleep_mode), .rtc_tick(rtc_tick), .nmi_pin(nmi_pin),
    .encoded_request_pins(encoded_request_pins), .edge_polarity_select(edge_polarity_select),
    .nmi_pass_block(nmi_pass_block), .independent_pin_mode(independent_pin_mode),
    .prio_we(prio_we), .priority_reg_d_wdata(priority_reg_d_wdata),
    .peri_level_wdata(peri_level_wdata), .priority_reg_d(priority_reg_d),
    .peri_level(peri_level), .peri_req(peri_req), .cpu_block_bit(cpu_block_bit),
    .cpu_mask_level(cpu_mask_level), .cpu_accept(cpu_accept), .int_req(int_req),
    .int_level(int_level), .event_code_reg(event_code_reg),
    .pending_source_reg(pending_source_reg), .nmi_pending(nmi_pending));

  isp_core_model isp_core_model_i (.sys_clk(sys_clk), .resetn(resetn), .acc_en(acc_en),
    .lag(lag), .int_req(int_req), .int_level(int_level), .cpu_mask_level(cpu_mask_level),
    .cpu_accept(cpu_accept));

  always #20 sys_clk = ~sys_clk;

  task automatic wrap_up;
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  always @(posedge sys_clk)
  begin
    cyc_cnt++;
    if (cyc_cnt == 20000)
    begin
      error_cnt++;
      wrap_up;
    end
  end

  task automatic chk(input string nm, input logic [35:0] seen, input logic [35:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("[ERR] %s exp %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  // model answers after a random lag; code lands one edge after the pulse
  task automatic take(input logic [11:0] code, input logic yes);
    logic got;
    got = 1'b0;
    lag = 4'($random(seed) & 3);
    acc_en = 1'b1;
    for (int i = 0; i < 12 && !got; i++)
    begin
      cyc(1);
      got = (cpu_accept === 1'b1);
    end
    cyc(1);
    chk("accept", got, yes);
    if (got)
      chk("event_code", event_code_reg, code);
    acc_en = 1'b0;
  endtask

  // strict compare keeps the lowest index on equal levels
  function automatic logic [8:0] best(input logic [35:0] lv, input logic [8:0] rq);
    logic [4:0] b;
    logic [3:0] ix;
    b = 5'h00;
    ix = 4'h0;
    for (int j = 0; j < 9; j++)
      if (rq[j] && {1'b0, lv[j*4+:4]} > b)
      begin
        b = {1'b0, lv[j*4+:4]};
        ix = 4'(j);
      end
    return {ix, b};
  endfunction

  initial
  begin
    repeat (12) @(posedge sys_clk);
    #1 resetn = 1;
    chk("prio_d", priority_reg_d, ISP_PRIO_D_RST);
    chk("peri_level", peri_level, 36'h0);
    for (int p = 0; p < 15; p++)
    begin
      encoded_request_pins = 4'(p);
      cyc(5);
      chk("irl_level", int_level, 5'(15 - p));
      take(ISP_EVT_IRL_BASE + ISP_EVT_IRL_STEP * 12'(p), 1'b1);
      encoded_request_pins = 4'hF;
      cyc(5);
    end
    encoded_request_pins = 4'h3;
    cyc(1);
    encoded_request_pins = 4'hF;
    cyc(5);
    chk("glitch", int_level, 5'h00);
    cpu_mask_level = 4'hC;
    encoded_request_pins = 4'h5;
    take(12'h000, 1'b0);
    encoded_request_pins = 4'hF;
    cpu_mask_level = 4'h0;
    cyc(5);
    nmi_pin = 1;
    cyc(2);
    chk("nmi_level", int_level, ISP_LVL_NMI);
    take(ISP_EVT_NMI, 1'b1);
    nmi_pin = 0;
    cyc(3);
    chk("nmi_fall", nmi_pending, 1'b0);
    cpu_block_bit = 1;
    nmi_pin = 1;
    cyc(3);
    chk("nmi_held", int_req, 1'b0);
    sleep_mode = 1;
    cyc(1);
    chk("nmi_sleep", int_req, 1'b1);
    sleep_mode = 0;
    nmi_pass_block = 1;
    cyc(1);
    chk("nmi_pass", int_req, 1'b1);
    take(ISP_EVT_NMI, 1'b1);
    nmi_pass_block = 0;
    cpu_block_bit = 0;
    edge_polarity_select = 0;
    cyc(1);
    nmi_pin = 0;
    cyc(8);
    chk("nmi_blind", nmi_pending, 1'b0);
    nmi_pin = 1;
    cyc(2);
    nmi_pin = 0;
    cyc(2);
    chk("nmi_falling", nmi_pending, 1'b1);
    take(ISP_EVT_NMI, 1'b1);
    independent_pin_mode = 1;
    for (int i = 0; i < 4; i++)
    begin
      encoded_request_pins = ~(4'h1 << i);
      cyc(5);
      chk("pin_level", int_level, {1'b0, ISP_PRIO_D_RST[15-4*i-:4]});
      take(ISP_EVT_IRL_BASE + ISP_EVT_IRL_STEP * 12'(3 * i + 2), 1'b1);
    end
    encoded_request_pins = 4'h0;
    cyc(5);
    chk("pin_order", int_level, 5'h0D);
    // new pin levels: pins 0 and 1 tie, pin 3 masked
    cpu_block_bit = 1;
    priority_reg_d_wdata = 16'h9940;
    prio_we = 1;
    cyc(1);
    prio_we = 0;
    cpu_block_bit = 0;
    chk("prio_d", priority_reg_d, 16'h9940);
    cyc(2);
    chk("pin_tie", int_level, 5'h09);
    take(ISP_EVT_IRL_BASE + ISP_EVT_IRL_STEP * 12'h002, 1'b1);
    encoded_request_pins = 4'h7;
    cyc(5);
    chk("pin_off", int_level, 5'h00);
    encoded_request_pins = 4'hF;
    independent_pin_mode = 0;
    cyc(5);
    for (int t = 0; t < 20; t++)
    begin
      cpu_block_bit = 1;
      for (int j = 0; j < 9; j++)
        peri_level_wdata[j*4+:4] = 4'($random(seed));
      if (t == 0)
        peri_level_wdata = {9{4'h5}};
      if (t == 1)
        peri_level_wdata = '0;
      prio_we = 1;
      cyc(1);
      prio_we = 0;
      cpu_block_bit = 0;
      chk("peri_level", peri_level, peri_level_wdata);
      peri_req = (t < 2) ? 9'h1FF : 9'($random(seed));
      cyc(3);
      win = best(peri_level_wdata, peri_req);
      chk("pending", pending_source_reg, peri_req);
      chk("peri_win", int_level, win[4:0]);
      take(ISP_EVT_PERI_BASE + ISP_EVT_PERI_STEP * 12'(win[8:5]), win[4:0] != 0);
      peri_req = '0;
      cyc(3);
    end
    standby_mode = 1;
    encoded_request_pins = 4'h5;
    cyc(6);
    chk("stby_hold", int_level, 5'h00);
    repeat (3)
    begin
      rtc_tick = 1;
      cyc(1);
      rtc_tick = 0;
      cyc(3);
    end
    cyc(2);
    chk("stby_tick", int_level, 5'h0A);
    wrap_up;
  end
endmodule
